// ==== core/trace_map.svh ====
// Register offsets, field positions, reset values and counts of the bus trace recorder.
`ifndef TRACE_MAP_SVH
`define TRACE_MAP_SVH
`define TR_CTRL_OFS      8'h00
`define TR_SUPP_OFS      8'h04
`define TR_EVENT_OFS     8'h08
`define TR_DELAY_OFS     8'h0C
`define TR_ACCTYPE_OFS   8'h10
`define TR_RANGELO_OFS   8'h14
`define TR_RANGEHI_OFS   8'h18
`define TR_ACCCNT_OFS    8'h1C
`define TR_STATUS_OFS    8'h20
`define TR_INDEX_OFS     8'h24
`define TR_RECA_OFS      8'h28
`define TR_RECB_OFS      8'h2C
`define TR_IRQCOND_OFS   8'h30
`define TR_STAMP_OFS     8'h34
`define TR_MONADDR_OFS   8'h38
`define TR_MONDATA_OFS   8'h3C
`define TR_CTRL_EN       0
`define TR_CTRL_TSMODE   1
`define TR_CTRL_IRQHI    2
`define TR_CTRL_STOPARM  3
`define TR_CTRL_RATE_LO  4
`define TR_CTRL_RATE_HI  6
`define TR_EVENT_AREA_LO 8
`define TR_EVENT_AREA_HI 14
`define TR_IRQ_LEVEL_LO  8
`define TR_IRQ_LEVEL_HI  15
`define TR_CTRL_RST      32'h0000_0000
`define TR_MASK_RST      5'h00
`define TR_AREA_RST      7'h7F
`define TR_DEPTH         64
`define TR_PTR_W         6
`define TR_CLK_MAX       4'h8
`endif

// ==== core/trace_pkg.sv ====
// Types shared by the bus trace recorder: tags, pin bundle, register request and record.
package trace_pkg;
   // Bus state tag as driven by the target's status pins.
   typedef enum logic [2:0] {ST_PREFETCH, ST_CPUDATA, ST_XFER, ST_AUX, ST_OTHER} busState_t;
   // Accessed area tag.
   typedef enum logic [2:0] {AR_ROM, AR_RAM, AR_IO16, AR_IO8, AR_EXTWIDE, AR_EXTNARROW,
                             AR_XFERRAM} area_t;
   // Capture sequencer states.
   typedef enum {CAP_IDLE, CAP_RUN, CAP_DELAY, CAP_HALT} capState_t;
   // Target bus pins as seen at the probe.
   typedef struct packed {
      logic        active;   // High for every clock of a bus cycle.
      logic [23:0] addr;     // Bus address.
      logic [15:0] data;     // Data bus.
      logic        wide;     // High for a 16-bit access.
      logic        write;    // High for a write.
      logic [2:0]  state;    // Bus state code.
      logic [2:0]  area;     // Area code.
      logic        lowSpeed; // High in the low-speed clock mode.
      logic [3:0]  probe;    // Probe 4 down to probe 1.
      logic        nmi;      // NMI input level.
      logic [15:0] irq;      // IRQ input levels 15 down to 0.
   } busPins_t;
   // Register port request.
   typedef struct packed {
      logic        we;       // Write strobe.
      logic        re;       // Read strobe.
      logic [7:0]  addr;     // Byte address.
      logic [31:0] wdata;    // Write data.
   } regReq_t;
   // One trace record.
   typedef struct packed {
      logic        tsMode;   // Aux holds a time stamp.
      logic [23:0] addr;     // Address.
      logic [15:0] data;     // Data, low byte only when narrow.
      logic        wide;     // Data width flag.
      logic        write;    // Read or write.
      logic [23:0] aux;      // Tag fields or time stamp.
   } traceRec_t;
endpackage

// ==== core/bus_trace_recorder.sv ====
// Bus trace recorder: samples each target bus cycle into a circular trace store.
//
// Behaviour
// - Tag each cycle with its bus state.
// - Tag each cycle with its accessed area.
// - Newest record is index 0, older negative.
// - With delay, stop cycle is 0, later positive.
// - Record holds the 24-bit address.
// - Record holds byte or 16-bit data.
// - Record holds a read/write flag.
// - Record holds normal or low-speed mode.
// - Record clock count 1-8, else overflow.
// - Record four probe pins, probe 4 highest.
// - Record the NMI input level.
// - Record eight IRQ levels, group selectable.
// - Time stamp mode replaces all tag fields.
// - Time stamp clears on each program start.
// - Time stamp advances at selectable rate.
// - Bus/area tags form an event condition.
// - State tag suppresses capture, selects counted access.
// - Monitoring never stalls the target program.
// - Each IRQ line matches high, low or ignored.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "trace_map.svh"

module bus_trace_recorder
   import trace_pkg::*;
(
   input  wire logic        clk,         // System clock, 10 MHz.
   input  wire logic        rst_b,       // Asynchronous reset, active low.
   input  wire regReq_t     regReq,      // Register request.
   output logic [31:0]      regRdata,    // Read data, one cycle after the strobe.
   input  wire busPins_t    busPins,     // Target bus pins.
   input  wire logic        runStart,    // Pulse when the user program starts.
   output logic             eventHit,    // Pulse when a cycle meets the event condition.
   output logic             traceHalted  // High once capture has stopped.
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Bus state select: codes above the known set count as other.
   function automatic logic stateHit(input logic [4:0] mask, input logic [2:0] st);
      logic hit;
      hit = (st > ST_OTHER) ? mask[ST_OTHER] : mask[st];
      return hit;
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   busPins_t           syncA_r;       // First synchroniser stage, read only by syncB_r.
   busPins_t           syncB_r;       // Second synchroniser stage.
   busPins_t           hold_r;        // Pins of the cycle in progress.
   logic               actPrev_r;     // Active level one clock ago.
   logic [3:0]         clkCnt_r;      // Clocks in the current bus cycle.
   logic               clkOvf_r;      // Cycle ran past eight clocks.
   logic               cycleDone;     // The bus cycle has just ended.
   logic [23:0]        stamp_r;       // Time stamp counter.
   logic [7:0]         preCnt_r;      // Time stamp prescaler.
   logic               stampTick;     // One time stamp step.
   logic [31:0]        ctrl_r;        // Control register.
   logic [4:0]         suppMask_r;    // States kept out of the trace.
   logic [4:0]         evState_r;     // States that meet the event condition.
   logic [6:0]         evArea_r;      // Areas that meet the event condition.
   logic [15:0]        delay_r;       // Cycles captured after the stop cycle.
   logic [4:0]         accType_r;     // States counted in the range measurement.
   logic [23:0]        rangeLo_r;     // Lower address of the counted range.
   logic [23:0]        rangeHi_r;     // Upper address of the counted range.
   logic [31:0]        accCnt_r;      // Access count.
   logic [7:0]         irqCare_r;     // IRQ lines that take part in the match.
   logic [7:0]         irqLevel_r;    // Level each such line must show.
   logic [7:0]         readIdx_r;     // Signed record index selected for readout.
   logic [23:0]        monAddr_r;     // Watched address.
   logic [15:0]        monData_r;     // Last value written to the watched address.
   traceRec_t          newRec;        // Record built from the ended cycle.
   traceRec_t          mem_r [`TR_DEPTH]; // Trace store.
   traceRec_t          selRec_r;      // Record picked for readout.
   logic [`TR_PTR_W-1:0] wrPtr_r;     // Next slot to fill.
   logic [`TR_PTR_W-1:0] stopPtr_r;   // Slot of the stop cycle.
   logic [`TR_PTR_W-1:0] refPtr;      // Slot of index 0.
   logic [`TR_PTR_W-1:0] rdPtr;       // Slot of the selected index.
   logic               wrapped_r;     // Store has been filled at least once.
   logic               delayUsed_r;   // Stop cycle anchors index 0.
   logic [15:0]        delayCnt_r;    // Cycles still to capture after the stop.
   capState_t          cap_r;         // Capture sequencer.
   logic [7:0]         irqSel;        // Selected IRQ group.
   logic [7:0]         irqOk;         // Per-line IRQ match.
   logic               evMatch;       // Event condition met by the ended cycle.
   logic               stopHit;       // Trace stop condition met.
   logic               suppress;      // Ended cycle is not to be stored.
   logic               capture;       // Store the ended cycle.

   // ****************************************************************
   // Pin sampling
   // ****************************************************************

   // Two flip-flops on every target pin; only syncB_r is used by logic.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         syncA_r <= '0;
         syncB_r <= '0;
      end
      else
      begin
         syncA_r <= busPins;
         syncB_r <= syncA_r;
      end
   end

   // ****************************************************************
   // Bus cycle measurement
   // ****************************************************************

   // Holds the pins while a cycle runs and counts its clocks.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hold_r    <= '0;
         actPrev_r <= 1'b0;
         clkCnt_r  <= 4'h0;
         clkOvf_r  <= 1'b0;
      end
      else
      begin
         actPrev_r <= syncB_r.active;
         if (syncB_r.active)
         begin
            hold_r <= syncB_r;
            // A fresh cycle restarts the count at one.
            if (!actPrev_r)
            begin
               clkCnt_r <= 4'h1;
               clkOvf_r <= 1'b0;
            end
            else if (clkCnt_r == `TR_CLK_MAX)
            begin
               clkOvf_r <= 1'b1;
            end
            else
            begin
               clkCnt_r <= clkCnt_r + 4'h1;
            end
         end
      end
   end

   // The cycle ends on the falling edge of the active level.
   assign cycleDone = actPrev_r && !syncB_r.active;

   // ****************************************************************
   // Time stamp
   // ****************************************************************

   // The prescaler steps the stamp once every two to the rate select clocks.
   assign stampTick = (preCnt_r == ((8'h01 << ctrl_r[`TR_CTRL_RATE_HI:`TR_CTRL_RATE_LO]) - 8'h01));

   // Stamp and prescaler restart together so each run begins at zero.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stamp_r  <= 24'h00_0000;
         preCnt_r <= 8'h00;
      end
      else if (runStart)
      begin
         stamp_r  <= 24'h00_0000;
         preCnt_r <= 8'h00;
      end
      else if (stampTick)
      begin
         stamp_r  <= stamp_r + 24'h00_0001;
         preCnt_r <= 8'h00;
      end
      else
      begin
         preCnt_r <= preCnt_r + 8'h01;
      end
   end

   // ****************************************************************
   // Record building and matching
   // ****************************************************************

   // The IRQ group select picks lines 7..0 or 15..8, highest first.
   assign irqSel = ctrl_r[`TR_CTRL_IRQHI] ? hold_r.irq[15:8] : hold_r.irq[7:0];

   // Each line is ignored, or must equal its programmed level.
   for (genvar i = 0; i < 8; i++)
   begin : gIrq
      assign irqOk[i] = !irqCare_r[i] || (irqSel[i] == irqLevel_r[i]);
   end

   // Builds the record; in stamp mode the tag fields give way to the stamp.
   always_comb
   begin
      newRec        = '0;
      newRec.tsMode = ctrl_r[`TR_CTRL_TSMODE];
      newRec.addr   = hold_r.addr;
      newRec.wide   = hold_r.wide;
      newRec.data   = hold_r.wide ? hold_r.data : {8'h00, hold_r.data[7:0]};
      newRec.write  = hold_r.write;
      if (ctrl_r[`TR_CTRL_TSMODE])
      begin
         newRec.aux = stamp_r;
      end
      else
      begin
         // Aux layout: area, state, mode, overflow, count-1, probes, NMI, IRQ.
         newRec.aux = {hold_r.area,
                       hold_r.state,
                       hold_r.lowSpeed,
                       clkOvf_r,
                       clkOvf_r ? 3'h7 : 3'(clkCnt_r - 4'h1),
                       hold_r.probe,
                       hold_r.nmi,
                       irqSel};
      end
   end

   // Bus state, area and IRQ lines together form the event condition.
   assign evMatch  = stateHit(evState_r, hold_r.state) && evArea_r[hold_r.area] &&
                     (&irqOk);
   assign stopHit  = evMatch && ctrl_r[`TR_CTRL_STOPARM];
   assign suppress = stateHit(suppMask_r, hold_r.state);
   // The stop cycle is always stored, since it must stand at index 0.
   assign capture  = cycleDone && (cap_r == CAP_RUN || cap_r == CAP_DELAY) &&
                     (!suppress || (stopHit && cap_r == CAP_RUN));

   // Event output is a registered one-clock pulse.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         eventHit <= 1'b0;
      end
      else
      begin
         eventHit <= cycleDone && evMatch;
      end
   end

   // ****************************************************************
   // Capture sequencer and store
   // ****************************************************************

   // Runs from program start until the stop cycle plus its delay.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cap_r       <= CAP_IDLE;
         wrPtr_r     <= '0;
         stopPtr_r   <= '0;
         wrapped_r   <= 1'b0;
         delayUsed_r <= 1'b0;
         delayCnt_r  <= 16'h0000;
      end
      else if (!ctrl_r[`TR_CTRL_EN])
      begin
         cap_r <= CAP_IDLE;
      end
      else
      begin
         if (capture)
         begin
            wrPtr_r <= wrPtr_r + 1'b1;
            if (&wrPtr_r)
            begin
               wrapped_r <= 1'b1;
            end
         end
         case (cap_r)
            CAP_IDLE, CAP_HALT:
            begin
               // A new run starts an empty trace.
               if (runStart)
               begin
                  cap_r       <= CAP_RUN;
                  wrPtr_r     <= '0;
                  wrapped_r   <= 1'b0;
                  delayUsed_r <= 1'b0;
               end
            end
            CAP_RUN:
            begin
               if (capture && stopHit)
               begin
                  stopPtr_r   <= wrPtr_r;
                  delayUsed_r <= (delay_r != 16'h0000);
                  delayCnt_r  <= delay_r;
                  cap_r       <= (delay_r == 16'h0000) ? CAP_HALT : CAP_DELAY;
               end
            end
            CAP_DELAY:
            begin
               if (capture)
               begin
                  delayCnt_r <= delayCnt_r - 16'h0001;
                  if (delayCnt_r == 16'h0001)
                  begin
                     cap_r <= CAP_HALT;
                  end
               end
            end
            default:
            begin
               cap_r <= CAP_IDLE;
            end
         endcase
      end
   end

   assign traceHalted = (cap_r == CAP_HALT);

   // The store only writes; the oldest slot is overwritten once it wraps.
   always_ff @(posedge clk)
   begin
      if (capture)
      begin
         mem_r[wrPtr_r] <= newRec;
      end
   end

   // Index 0 is the newest record, or the stop cycle when a delay was used.
   assign refPtr = delayUsed_r ? stopPtr_r : (wrPtr_r - 1'b1);
   assign rdPtr  = refPtr + readIdx_r[`TR_PTR_W-1:0];

   // ****************************************************************
   // Range access count and memory monitor
   // ****************************************************************

   // Counts ended bus cycles of the chosen state that fall in the range, stored or not.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         accCnt_r <= 32'h0000_0000;
      end
      else if (runStart)
      begin
         accCnt_r <= 32'h0000_0000;
      end
      else if (cycleDone && stateHit(accType_r, hold_r.state) &&
               hold_r.addr >= rangeLo_r && hold_r.addr <= rangeHi_r)
      begin
         accCnt_r <= accCnt_r + 32'h0000_0001;
      end
   end

   // Shadows writes to the watched address; purely passive, so the target never waits.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         monData_r <= 16'h0000;
      end
      else if (cycleDone && hold_r.write && hold_r.addr == monAddr_r)
      begin
         monData_r <= newRec.data;
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************

   // Software writes; every register answers at once, with no wait.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_r     <= `TR_CTRL_RST;
         suppMask_r <= `TR_MASK_RST;
         evState_r  <= `TR_MASK_RST;
         evArea_r   <= `TR_AREA_RST;
         delay_r    <= 16'h0000;
         accType_r  <= `TR_MASK_RST;
         rangeLo_r  <= 24'h00_0000;
         rangeHi_r  <= 24'hFF_FFFF;
         irqCare_r  <= 8'h00;
         irqLevel_r <= 8'h00;
         readIdx_r  <= 8'h00;
         monAddr_r  <= 24'h00_0000;
      end
      else if (regReq.we)
      begin
         case (regReq.addr)
            `TR_CTRL_OFS:    ctrl_r     <= regReq.wdata;
            `TR_SUPP_OFS:    suppMask_r <= regReq.wdata[4:0];
            `TR_EVENT_OFS:
            begin
               evState_r <= regReq.wdata[4:0];
               evArea_r  <= regReq.wdata[`TR_EVENT_AREA_HI:`TR_EVENT_AREA_LO];
            end
            `TR_DELAY_OFS:   delay_r    <= regReq.wdata[15:0];
            `TR_ACCTYPE_OFS: accType_r  <= regReq.wdata[4:0];
            `TR_RANGELO_OFS: rangeLo_r  <= regReq.wdata[23:0];
            `TR_RANGEHI_OFS: rangeHi_r  <= regReq.wdata[23:0];
            `TR_IRQCOND_OFS:
            begin
               irqCare_r  <= regReq.wdata[7:0];
               irqLevel_r <= regReq.wdata[`TR_IRQ_LEVEL_HI:`TR_IRQ_LEVEL_LO];
            end
            `TR_INDEX_OFS:   readIdx_r  <= regReq.wdata[7:0];
            `TR_MONADDR_OFS: monAddr_r  <= regReq.wdata[23:0];
            default:
            begin
               // Unmapped writes are dropped.
            end
         endcase
      end
   end

   // The selected record is fetched each clock, so a read sees the current index.
   always_ff @(posedge clk)
   begin
      selRec_r <= mem_r[rdPtr];
   end

   // Read data stand in the cycle after the strobe and read zero otherwise.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         regRdata <= 32'h0000_0000;
      end
      else if (regReq.re)
      begin
         case (regReq.addr)
            `TR_CTRL_OFS:    regRdata <= ctrl_r;
            `TR_SUPP_OFS:    regRdata <= {27'h0, suppMask_r};
            `TR_EVENT_OFS:   regRdata <= {17'h0, evArea_r, 3'h0, evState_r};
            `TR_DELAY_OFS:   regRdata <= {16'h0, delay_r};
            `TR_ACCTYPE_OFS: regRdata <= {27'h0, accType_r};
            `TR_RANGELO_OFS: regRdata <= {8'h0, rangeLo_r};
            `TR_RANGEHI_OFS: regRdata <= {8'h0, rangeHi_r};
            `TR_ACCCNT_OFS:  regRdata <= accCnt_r;
            `TR_STATUS_OFS:  regRdata <= {8'h0, 2'h0, stopPtr_r, 2'h0, wrPtr_r,
                                          4'h0, delayUsed_r, wrapped_r,
                                          traceHalted, cap_r != CAP_IDLE};
            `TR_INDEX_OFS:   regRdata <= {24'h0, readIdx_r};
            `TR_RECA_OFS:    regRdata <= {selRec_r.tsMode, 5'h0, selRec_r.wide,
                                          selRec_r.write, selRec_r.addr};
            `TR_RECB_OFS:    regRdata <= {selRec_r.aux[15:0], selRec_r.data};
            `TR_IRQCOND_OFS: regRdata <= {16'h0, irqLevel_r, irqCare_r};
            `TR_STAMP_OFS:   regRdata <= {selRec_r.aux[23:16], stamp_r};
            `TR_MONADDR_OFS: regRdata <= {8'h0, monAddr_r};
            `TR_MONDATA_OFS: regRdata <= {16'h0, monData_r};
            default:         regRdata <= 32'h0000_0000;
         endcase
      end
      else
      begin
         regRdata <= 32'h0000_0000;
      end
   end

endmodule

// ==== testbench/bus_trace_recorder_asserts.sv ====
// Port checker of the bus trace recorder.
`timescale 1ns/1ns
`include "trace_map.svh"
module bus_trace_recorder_asserts
   import trace_pkg::*;
(
   input wire logic        clk,        // Clock.
   input wire logic        rst_b,      // Reset, active low.
   input wire regReq_t     regReq,     // Register request.
   input wire logic [31:0] regRdata,   // Read data.
   input wire busPins_t    busPins,    // Target pins.
   input wire logic        runStart,   // Start pulse.
   input wire logic        eventHit,   // Event pulse.
   input wire logic        traceHalted // Capture stopped.
);
   // ************
   // Properties
   // ************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Cycles are two clocks apart at least, so a hit is one pulse.
   a_event_pulse:
      assert property (eventHit |=> !eventHit) else $error("event pulse held");
   a_event_cause:
      assert property (eventHit |-> $past(busPins.active, 3) || $past(busPins.active, 4)
         || $past(busPins.active, 5)) else $error("event without bus cycle");
   a_halt_holds:
      assert property (traceHalted && !runStart && !regReq.we |=> traceHalted)
         else $error("halt dropped");
   a_read_idle:
      assert property (!$past(regReq.re) |-> regRdata == 32'h0) else $error("stray data");
   a_read_unmapped:
      assert property (regReq.re && regReq.addr > 8'h3C |=> regRdata == 32'h0)
         else $error("unmapped read not zero");
   a_ctrl_back:
      assert property (regReq.we && regReq.addr == `TR_CTRL_OFS ##2 regReq.re
         && regReq.addr == `TR_CTRL_OFS |=> regRdata[6:0] == 7'($past(regReq.wdata, 3)))
         else $error("control readback differs");
   a_cond_back:
      assert property (regReq.we && regReq.addr == `TR_IRQCOND_OFS ##2 regReq.re
         && regReq.addr == `TR_IRQCOND_OFS |=> regRdata[15:0] == 16'($past(regReq.wdata, 3)))
         else $error("condition readback differs");
   a_stamp_restart:
      assert property (runStart ##1 regReq.re && regReq.addr == `TR_STAMP_OFS
         |=> regRdata[23:0] < 24'h4) else $error("stamp not restarted");
   c_event: cover property (eventHit);
   c_start: cover property (runStart ##[1:300] eventHit);
   c_record: cover property (regReq.re && regReq.addr == `TR_RECB_OFS);
endmodule
bind bus_trace_recorder bus_trace_recorder_asserts i_chk (.clk(clk), .rst_b(rst_b),
   .regReq(regReq), .regRdata(regRdata), .busPins(busPins), .runStart(runStart),
   .eventHit(eventHit), .traceHalted(traceHalted));

// ==== testbench/target_bus_model.sv ====
// Behavioural model of the target bus seen at the probe.
`timescale 1ns/1ns
module target_bus_model
   import trace_pkg::*;
(
   input  wire logic clk,    // Clock.
   output busPins_t  busPins // Pins toward the recorder.
);
   initial busPins = '0;
   // One bus cycle of len clocks, then a two-clock gap.
   task automatic cyc(input busPins_t p, input int len);
      busPins_t q;
      p.active = 1'b1;
      q = p;
      @(posedge clk);
      busPins <= p;
      repeat (len) @(posedge clk);
      // Released data shows the inverse so a stale value never passes.
      q.data = ~p.data;
      q.active = 1'b0;
      busPins <= q;
      repeat (2) @(posedge clk);
   endtask
endmodule

// ==== testbench/bus_trace_recorder_tb_top.sv ====
// Self-checking testbench of the bus trace recorder.
`timescale 1ns/1ns
`include "trace_map.svh"
`define CHK(got, exp) \
   begin \
      samplesChecked++; \
      if ((got) !== (exp)) \
      begin \
         nErrors++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module bus_trace_recorder_tb_top
   import trace_pkg::*;
;
   logic        clk, rst_b, runStart, eventHit, traceHalted; // Design pins.
   logic [31:0] regRdata, lfsr, ctrl;                        // Read data, seed, control.
   logic [95:0] tmp;                                         // Random pool.
   logic [23:0] aux;                                         // Expected tag word.
   regReq_t     regReq;                                      // Register request.
   busPins_t    busPins, p;                                  // Pins and one cycle.
   busPins_t    recQ[$];                                     // Model of stored cycles.
   int          lenQ[$], nErrors, samplesChecked, cycles, hits, cfg, i, n, len;
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   bus_trace_recorder i_dut (.clk(clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
      .busPins(busPins), .runStart(runStart), .eventHit(eventHit), .traceHalted(traceHalted));
   target_bus_model i_bus (.clk(clk), .busPins(busPins));
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Each access leaves one idle cycle so no signal is driven twice in a step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regReq <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      regReq <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      regReq <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      regReq <= '0;
      @(posedge clk);
      `CHK(regRdata & m, e & m)
   endtask
   task automatic testDone();
      if (nErrors == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Counts hits and cuts a hang short.
   always @(posedge clk)
   begin
      cycles++;
      if (eventHit === 1'b1)
         hits++;
      if (cycles == 20000)
      begin
         nErrors++;
         testDone();
      end
   end
   initial
   begin
      rst_b = 1'b0;
      regReq = '0;
      runStart = 1'b0;
      lfsr = 32'hD90E;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(8'h40, 32'h0, 32'hFFFFFFFF);
      wr(`TR_IRQCOND_OFS, 32'hA5C3);
      rd(`TR_IRQCOND_OFS, 32'hA5C3, 32'hFFFF);
      wr(`TR_EVENT_OFS, 32'h7F1F);
      wr(`TR_DELAY_OFS, 32'h2);
      // Low group, high group with other-state suppressed, stamps, then stop with delay 2.
      for (cfg = 0; cfg < 4; cfg++)
      begin
         ctrl = (cfg == 0) ? 32'h1 : (cfg == 1) ? 32'h5 : (cfg == 2) ? 32'h3 : 32'h9;
         wr(`TR_SUPP_OFS, (cfg == 1) ? 32'h10 : 32'h0);
         wr(`TR_CTRL_OFS, ctrl);
         rd(`TR_CTRL_OFS, ctrl, 32'h7F);
         runStart <= 1'b1;
         @(posedge clk);
         runStart <= 1'b0;
         rd(`TR_STAMP_OFS, 32'h0, 32'hFFFFFC);
         recQ.delete();
         lenQ.delete();
         for (i = 0; i < 7; i++)
         begin
            tmp = {lfsr, nextRand(lfsr), nextRand(~lfsr)};
            lfsr = nextRand(lfsr);
            p = tmp[70:0];
            p.state = 3'(i % 5);
            p.area = 3'(i);
            // Cared IRQ lines match the programmed levels except in cycle 5.
            p.irq = (p.irq & 16'h3C3C) | ((i == 5) ? 16'h8080 : 16'h8181);
            len = (i == 0) ? 1 : i + 3;
            i_bus.cyc(p, len);
            if (!(cfg == 1 && i == 4) && !(cfg == 3 && i > 2))
            begin
               recQ.push_back(p);
               lenQ.push_back(len);
            end
         end
         repeat (6) @(posedge clk);
         `CHK(hits, 6 * (cfg + 1))
         `CHK(traceHalted, cfg == 3)
         n = recQ.size();
         for (i = 0; i < n; i++)
         begin
            p = recQ[i];
            len = lenQ[i];
            aux = {p.area, p.state, p.lowSpeed, len > 8, 3'(len - 1), p.probe, p.nmi,
                   (cfg == 1) ? p.irq[15:8] : p.irq[7:0]};
            wr(`TR_INDEX_OFS, (cfg == 3) ? 32'(i) : 32'(i - n + 1));
            rd(`TR_RECA_OFS, {cfg == 2, 5'h0, p.wide, p.write, p.addr}, 32'hFFFFFFFF);
            rd(`TR_RECB_OFS, {aux[15:0], p.wide ? p.data : {8'h0, p.data[7:0]}},
               (cfg == 2) ? 32'hFFFF : (len > 8) ? 32'h1FFFFFFF : 32'hFFFFFFFF);
            if (cfg != 2)
               rd(`TR_STAMP_OFS, {aux[23:16], 24'h0}, 32'hFF000000);
         end
      end
      testDone();
   end
endmodule
